// ---- pkg/prbsc_consts.svh ----
// Register offsets, field positions and reset values of the sequence checker
`ifndef PRBSC_CONSTS_SVH
`define PRBSC_CONSTS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define PRBSC_OFF_CTRL      8'h00
`define PRBSC_OFF_CMD       8'h04
`define PRBSC_OFF_TOT_LIM   8'h08
`define PRBSC_OFF_ERR_LIM   8'h0c
`define PRBSC_OFF_TOT_CNT   8'h10
`define PRBSC_OFF_ERR_CNT   8'h14
`define PRBSC_OFF_STATUS    8'h18
`define PRBSC_OFF_INT_STAT  8'h1c
`define PRBSC_OFF_INT_MASK  8'h20

// ---------------------------------------------------------------
// Control fields
// ---------------------------------------------------------------
`define PRBSC_CTRL_CLK_POL  0
`define PRBSC_CTRL_DAT_POL  1
`define PRBSC_CTRL_QUAL_EN  2
`define PRBSC_CTRL_QUAL_POL 3
`define PRBSC_CTRL_EXT_RST  4
`define PRBSC_CTRL_POLY_LO  8
`define PRBSC_CTRL_POLY_HI  10
`define PRBSC_CMD_START     0
`define PRBSC_CMD_STOP      1

// ---------------------------------------------------------------
// Status and interrupt fields
// ---------------------------------------------------------------
`define PRBSC_ST_BUSY       0
`define PRBSC_ST_FILL       1
`define PRBSC_ST_DONE       2
`define PRBSC_ST_END_TOT    3
`define PRBSC_ST_END_ERR    4
`define PRBSC_INT_DONE      0
`define PRBSC_INT_RESYNC    1

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define PRBSC_CTRL_RST      32'h0000_0000
`define PRBSC_TOT_LIM_RST   32'hffff_ffff
`define PRBSC_ERR_LIM_RST   32'hffff_ffff
`define PRBSC_INT_MASK_RST  2'h0

`endif

// ---- pkg/prbsc_pkg.sv ----
// Types shared by the sequence checker modules
package prbsc_pkg;

  typedef enum logic [2:0] {
    PRBSC_PN9,
    PRBSC_PN11,
    PRBSC_PN15,
    PRBSC_PN16,
    PRBSC_PN20,
    PRBSC_PN21,
    PRBSC_DEGREE_TWENTYTHREE_POLYNOMIAL
  } prbsc_poly_t;

  typedef enum logic [1:0] {
    PRBSC_IDLE,
    PRBSC_FILL,
    PRBSC_CHECK,
    PRBSC_DONE
  } prbsc_state_t;

endpackage : prbsc_pkg

// ---- core/prbsc_lfsr.sv ----
// Feedback shift register: fills from received bits, then predicts the stream
`timescale 1ns/1ps

module prbsc_lfsr
  import prbsc_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        clear_in,
  input  wire logic        shift_in,
  input  wire logic        fill_in,
  input  wire logic        bit_in,
  input  wire logic [2:0]  poly_sel_in,
  output logic             predict_out,
  output logic             invert_out,
  output logic [4:0]       degree_out
);

  logic [22:0] sr_q;
  logic [4:0]  t1;
  logic [4:0]  t2;
  logic [4:0]  t3;
  logic        fb;

  // ---------------------------------------------------------------
  // Polynomial table
  // ---------------------------------------------------------------
  always_comb begin
    t2         = 5'h00;
    t3         = 5'h00;
    invert_out = 1'b0;
    unique case (prbsc_poly_t'(poly_sel_in))   // see [R17]
      PRBSC_PN9:  begin degree_out = 5'h09; t1 = 5'h04; end
      PRBSC_PN11: begin degree_out = 5'h0b; t1 = 5'h02; end
      PRBSC_PN15: begin degree_out = 5'h0f; t1 = 5'h01; invert_out = 1'b1; end
      PRBSC_PN16: begin degree_out = 5'h10; t1 = 5'h05; t2 = 5'h03; t3 = 5'h02; end
      PRBSC_PN20: begin degree_out = 5'h14; t1 = 5'h03; end
      PRBSC_PN21: begin degree_out = 5'h15; t1 = 5'h02; end
      PRBSC_DEGREE_TWENTYTHREE_POLYNOMIAL: begin degree_out = 5'h17; t1 = 5'h05; invert_out = 1'b1; end
      default:    begin degree_out = 5'h09; t1 = 5'h04; end
    endcase
  end

  // Bit k is the one received k+1 bits ago; period is 2^n - 1
  always_comb begin
    fb = sr_q[degree_out - 5'h01] ^ sr_q[t1 - 5'h01];   // see [R9]
    if (t2 != 5'h00) begin
      fb = fb ^ sr_q[t2 - 5'h01];
    end
    if (t3 != 5'h00) begin
      fb = fb ^ sr_q[t3 - 5'h01];
    end
  end

  assign predict_out = fb;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sr_q <= '0;
    end else if (clear_in) begin
      sr_q <= '0;
    end else if (shift_in) begin
      sr_q <= {sr_q[21:0], fill_in ? bit_in : fb};   // see [R3]
    end
  end

endmodule : prbsc_lfsr

// ---- core/prbsc_checker.sv ----
// Sequence bit error checker with APB registers and interrupt
//
// Operation
// [R1] Device under test returns serial data bits with an accompanying bit clock.
// [R2] Clock polarity, data polarity, polynomial and measurement length are configurable.
// [R3] Shift register fills from received bits, then switches to self-running feedback.
// [R4] No errors are flagged or counted while the register is filling.
// [R5] After filling, each received bit is compared with the prediction; mismatch counts.
// [R6] One counter of evaluated bits and one of faulty bits.
// [R7] About half the bits faulty means wrong seed: discard silently and refill. The code also sets the resync interrupt flag.
// [R8] Checking may start at any position of the incoming stream.
// [R9] Reference sequence repeats every two to the degree minus one bits.
// [R10] Internal restart mode uses only bit clock and data, no external restart.
// [R11] Optional data-valid qualifier with selectable polarity excludes extraneous bits.
// [R12] With active-high qualifier, bits count only while qualifier is one.
// [R13] Outside party drives the qualifier aligned with the bits it qualifies.
// [R14] External restart mode: restart high holds measurement reset, low runs it.
// [R15] Total and faulty bit counters are 32 bits wide.
// [R16] Measurement ends at total or error limit and reports which limit ended it.
// [R17] Feedback taps follow the selected polynomial, degrees 9 to 23, some inverted.
// [R18] Data and qualifier are sampled on the selected bit clock edge.
// [R19] Data polarity inversion applies before loading and before comparing.
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "prbsc_consts.svh"

module prbsc_checker
  import prbsc_pkg::*;
#(
  parameter int WIN_BITS     = 64,
  parameter int WIN_ERR_MIN  = 24
)
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        bit_clk_in,
  input  wire logic        bit_data_in,
  input  wire logic        data_valid_qualifier_in,
  input  wire logic        measurement_restart_input_in,
  output logic             irq_out
);

  // ---------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------
  generate
    if (WIN_BITS < 8 || WIN_BITS > 65535 || WIN_ERR_MIN < 1 || WIN_ERR_MIN > WIN_BITS) begin : g_bad
      $error("prbsc_checker: window parameters out of range");
    end
  endgenerate

  localparam logic [15:0] WIN_LAST = 16'(WIN_BITS - 1);
  localparam logic [15:0] WIN_THR  = 16'(WIN_ERR_MIN);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [31:0]  ctrl_q;
  logic [31:0]  tot_lim_q;
  logic [31:0]  err_lim_q;
  logic [31:0]  tot_cnt_q;
  logic [31:0]  err_cnt_q;
  logic [1:0]   int_stat_q;
  logic [1:0]   int_mask_q;
  logic [31:0]  prdata_q;
  logic         slverr_q;
  logic         end_tot_q;
  logic         end_err_q;
  prbsc_state_t state_q;
  logic [4:0]   fill_cnt_q;
  logic [15:0]  win_cnt_q;
  logic [15:0]  win_err_q;
  logic [3:0]   s1_q;
  logic [3:0]   s2_q;
  logic         clk_prev_q;
  logic         setup;
  logic         wr_en;
  logic         mapped;
  logic         start_cmd;
  logic         stop_cmd;
  logic         bit_edge;
  logic         bit_val;
  logic         valid;
  logic         hold_rst;
  logic         chk_bit;
  logic         mismatch;
  logic         tot_hit;
  logic         err_hit;
  logic         resync;
  logic         done_ev;
  logic         predict;
  logic         invert;
  logic [4:0]   degree;
  logic [31:0]  tot_next;
  logic [31:0]  err_next;
  logic [31:0]  status;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Clock, data, qualifier and restart share one chain so they stay aligned
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_q       <= 4'h0;
      s2_q       <= 4'h0;
      clk_prev_q <= 1'b0;
    end else begin
      s1_q       <= {measurement_restart_input_in, data_valid_qualifier_in, bit_data_in, bit_clk_in};  // see [R1]
      s2_q       <= s1_q;
      clk_prev_q <= s2_q[0];
    end
  end

  // ---------------------------------------------------------------
  // Bit qualification
  // ---------------------------------------------------------------
  assign bit_edge = ctrl_q[`PRBSC_CTRL_CLK_POL] ? (clk_prev_q & ~s2_q[0])
                                                : (~clk_prev_q & s2_q[0]);   // see [R18]
  assign bit_val  = s2_q[1] ^ ctrl_q[`PRBSC_CTRL_DAT_POL] ^ invert;          // see [R19]
  // Qualifier polarity bit set means active high
  assign valid    = ~ctrl_q[`PRBSC_CTRL_QUAL_EN]
                  | (s2_q[2] == ctrl_q[`PRBSC_CTRL_QUAL_POL]);               // see [R11] see [R12] see [R13]
  assign hold_rst = ctrl_q[`PRBSC_CTRL_EXT_RST] & s2_q[3];                   // see [R14]
  assign chk_bit  = bit_edge & valid & ~hold_rst & (state_q == PRBSC_CHECK);
  assign mismatch = bit_val ^ predict;                                       // see [R5]
  assign tot_next = tot_cnt_q + 32'h0000_0001;
  assign err_next = err_cnt_q + {31'h0, mismatch};
  assign tot_hit  = chk_bit & (tot_next >= tot_lim_q);                       // see [R16]
  assign err_hit  = chk_bit & mismatch & (err_next >= err_lim_q);
  assign resync   = chk_bit & (win_cnt_q == WIN_LAST)
                  & ((win_err_q + {15'h0, mismatch}) >= WIN_THR);            // see [R7]
  assign done_ev  = (tot_hit | err_hit) & ~resync;

  // ---------------------------------------------------------------
  // Shift register
  // ---------------------------------------------------------------
  prbsc_lfsr u_lfsr (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .clear_in    (start_cmd | hold_rst | resync),
    .shift_in    (bit_edge & valid & ~hold_rst & (state_q == PRBSC_FILL || state_q == PRBSC_CHECK)),
    .fill_in     (state_q == PRBSC_FILL),
    .bit_in      (bit_val),
    .poly_sel_in (ctrl_q[`PRBSC_CTRL_POLY_HI:`PRBSC_CTRL_POLY_LO]),
    .predict_out (predict),
    .invert_out  (invert),
    .degree_out  (degree)
  );

  // ---------------------------------------------------------------
  // Measurement state
  // ---------------------------------------------------------------
  // Seeding starts at whatever bit arrives next; no frame alignment
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q    <= PRBSC_IDLE;
      fill_cnt_q <= 5'h00;
    end else if (stop_cmd) begin
      state_q    <= PRBSC_IDLE;
      fill_cnt_q <= 5'h00;
    end else if (start_cmd || resync || (hold_rst && state_q != PRBSC_IDLE)) begin
      state_q    <= PRBSC_FILL;   // see [R8] see [R14]
      fill_cnt_q <= 5'h00;
    end else begin
      unique case (state_q)
        PRBSC_IDLE: begin
        end
        PRBSC_FILL: begin
          if (bit_edge && valid) begin
            if (fill_cnt_q == degree - 5'h01) begin
              state_q <= PRBSC_CHECK;   // see [R3]
            end
            fill_cnt_q <= fill_cnt_q + 5'h01;
          end
        end
        PRBSC_CHECK: begin
          if (done_ev) begin
            state_q <= PRBSC_DONE;
          end
        end
        PRBSC_DONE: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Counters
  // ---------------------------------------------------------------
  // Filling bits never reach these counters since chk_bit needs CHECK
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tot_cnt_q <= 32'h0000_0000;
      err_cnt_q <= 32'h0000_0000;
    end else if (start_cmd || resync || hold_rst) begin
      tot_cnt_q <= 32'h0000_0000;
      err_cnt_q <= 32'h0000_0000;
    end else if (chk_bit) begin
      tot_cnt_q <= tot_next;   // see [R4] see [R6] see [R15]
      err_cnt_q <= err_next;
    end
  end

  // Seed check window; runs in internal mode with only clock and data
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      win_cnt_q <= 16'h0000;
      win_err_q <= 16'h0000;
    end else if (start_cmd || resync || hold_rst || (chk_bit && win_cnt_q == WIN_LAST)) begin
      win_cnt_q <= 16'h0000;   // see [R10]
      win_err_q <= 16'h0000;
    end else if (chk_bit) begin
      win_cnt_q <= win_cnt_q + 16'h0001;
      win_err_q <= win_err_q + {15'h0, mismatch};
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      end_tot_q <= 1'b0;
      end_err_q <= 1'b0;
    end else if (start_cmd || stop_cmd) begin
      end_tot_q <= 1'b0;
      end_err_q <= 1'b0;
    end else if (done_ev && state_q == PRBSC_CHECK) begin
      end_tot_q <= tot_hit;   // see [R16]
      end_err_q <= err_hit;
    end
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // Read data is captured in the setup cycle so the access needs no wait
  assign setup     = psel_in & ~penable_in;
  assign wr_en     = psel_in & penable_in & pwrite_in & mapped;
  assign start_cmd = wr_en & (paddr_in == `PRBSC_OFF_CMD) & pwdata_in[`PRBSC_CMD_START];
  assign stop_cmd  = wr_en & (paddr_in == `PRBSC_OFF_CMD) & pwdata_in[`PRBSC_CMD_STOP] & ~start_cmd;
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & slverr_q;
  assign prdata_out  = prdata_q;

  assign status = {27'h0, end_err_q, end_tot_q, state_q == PRBSC_DONE, state_q == PRBSC_FILL,
                   state_q == PRBSC_FILL || state_q == PRBSC_CHECK};

  always_comb begin
    unique case (paddr_in)
      `PRBSC_OFF_CTRL, `PRBSC_OFF_CMD, `PRBSC_OFF_TOT_LIM, `PRBSC_OFF_ERR_LIM,
      `PRBSC_OFF_TOT_CNT, `PRBSC_OFF_ERR_CNT, `PRBSC_OFF_STATUS,
      `PRBSC_OFF_INT_STAT, `PRBSC_OFF_INT_MASK: mapped = 1'b1;
      default:                                  mapped = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else if (setup) begin
      slverr_q <= ~mapped;
      unique case (paddr_in)
        `PRBSC_OFF_CTRL:     prdata_q <= ctrl_q;
        `PRBSC_OFF_TOT_LIM:  prdata_q <= tot_lim_q;
        `PRBSC_OFF_ERR_LIM:  prdata_q <= err_lim_q;
        `PRBSC_OFF_TOT_CNT:  prdata_q <= tot_cnt_q;
        `PRBSC_OFF_ERR_CNT:  prdata_q <= err_cnt_q;
        `PRBSC_OFF_STATUS:   prdata_q <= status;
        `PRBSC_OFF_INT_STAT: prdata_q <= {30'h0, int_stat_q};
        `PRBSC_OFF_INT_MASK: prdata_q <= {30'h0, int_mask_q};
        default:             prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_q     <= `PRBSC_CTRL_RST;
      tot_lim_q  <= `PRBSC_TOT_LIM_RST;
      err_lim_q  <= `PRBSC_ERR_LIM_RST;
      int_mask_q <= `PRBSC_INT_MASK_RST;
    end else if (wr_en) begin
      if (paddr_in == `PRBSC_OFF_CTRL) begin
        ctrl_q <= pwdata_in & 32'h0000_071f;   // see [R2]
      end
      if (paddr_in == `PRBSC_OFF_TOT_LIM) begin
        tot_lim_q <= pwdata_in;
      end
      if (paddr_in == `PRBSC_OFF_ERR_LIM) begin
        err_lim_q <= pwdata_in;
      end
      if (paddr_in == `PRBSC_OFF_INT_MASK) begin
        int_mask_q <= pwdata_in[1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt
  // ---------------------------------------------------------------
  // Hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      int_stat_q <= 2'h0;
    end else begin
      int_stat_q <= (int_stat_q & ~((wr_en && paddr_in == `PRBSC_OFF_INT_STAT) ? pwdata_in[1:0] : 2'h0))
                  | {resync, done_ev && state_q == PRBSC_CHECK};
    end
  end

  assign irq_out = |(int_stat_q & int_mask_q);

endmodule : prbsc_checker

// ---- tb/prbsc_checker_asserts.sv ----
// Port-level assertions of the sequence checker, bound to its top module
`timescale 1ns/1ps

module prbsc_checker_chk #(
  parameter int WIN_BITS    = 64,
  parameter int WIN_ERR_MIN = 24
)(
  input wire logic        core_clk_in,
  input wire logic        rst_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        bit_clk_in,
  input wire logic        bit_data_in,
  input wire logic        data_valid_qualifier_in,
  input wire logic        measurement_restart_input_in,
  input wire logic        irq_out
);
  logic       acc;
  logic       bclk_q;
  logic [3:0] quiet_q;

  assign acc = psel_in && penable_in;

  // Cycles since the last bit clock change; irq may only rise shortly after one or after a bus write
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bclk_q  <= 1'b0;
      quiet_q <= 4'hf;
    end else begin
      bclk_q  <= bit_clk_in;
      quiet_q <= (bclk_q != bit_clk_in) ? 4'h0 : ((quiet_q == 4'hf) ? quiet_q : quiet_q + 4'h1);
    end
  end

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  AST_PREADY_NOWAIT:
    assert property (acc |-> pready_out) else $error("pready low in access phase");
  AST_SLVERR_PHASE:
    assert property (pslverr_out |-> acc) else $error("pslverr outside access phase");
  AST_SLVERR_UNMAPPED:
    assert property (acc && paddr_in > 8'h20 |-> pslverr_out) else $error("no error on unmapped address");
  AST_MAPPED_OK:
    assert property (acc && paddr_in <= 8'h20 && paddr_in[1:0] == 2'h0 |-> !pslverr_out)
      else $error("error on mapped address");
  AST_ERR_READ_ZERO:
    assert property (acc && pslverr_out && !pwrite_in |-> prdata_out == 32'h0) else $error("refused read not zero");
  AST_CMD_READ_ZERO:
    assert property (acc && !pwrite_in && paddr_in == 8'h04 |-> prdata_out == 32'h0) else $error("command reads nonzero");
  AST_RDATA_HOLD:
    assert property (!psel_in |=> $stable(prdata_out)) else $error("read data moved while idle");
  AST_IRQ_CAUSE:
    assert property ($rose(irq_out) |-> $past(acc && pwrite_in) || quiet_q < 4'hc)
      else $error("irq rose without bit or write");
  AST_IRQ_FALL_WRITE:
    assert property ($fell(irq_out) |-> $past(acc && pwrite_in)) else $error("irq fell without write");

  cover property (acc && pslverr_out);
  cover property ($rose(irq_out));
  cover property ($fell(irq_out));
endmodule : prbsc_checker_chk

bind prbsc_checker prbsc_checker_chk #(.WIN_BITS(WIN_BITS), .WIN_ERR_MIN(WIN_ERR_MIN)) chk_u (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .bit_clk_in(bit_clk_in), .bit_data_in(bit_data_in),
  .data_valid_qualifier_in(data_valid_qualifier_in),
  .measurement_restart_input_in(measurement_restart_input_in), .irq_out(irq_out));

// ---- tb/prbsc_dut_model.sv ----
// Far-side model: device returning sequence bits with a bit clock
`timescale 1ns/1ps

module prbsc_dut_model (
  output logic bit_clk_out,
  output logic bit_data_out,
  output logic valid_out,
  input  logic run_in,
  input  logic clk_inv_in,
  input  logic inv_in,
  input  logic vmode_in,
  input  int   deg_in,
  input  int   tap_in,
  input  int   err_first_in,
  input  int   err_per_in
);
  logic [22:0] hist_q = 23'h7f_ffff;
  logic        clk_raw;
  logic        nb;
  int          cnt;

  assign bit_clk_out = clk_raw ^ clk_inv_in;

  // Clock stands still between frames; idle data toggles so stale values never match
  initial begin
    clk_raw = 1'b0;
    bit_data_out = 1'b0;
    valid_out = 1'b1;
    cnt = 0;
    forever begin
      if (run_in) begin
        nb = hist_q[deg_in-1] ^ hist_q[tap_in-1];
        if (vmode_in && cnt % 4 == 3) begin
          valid_out = 1'b0;
          bit_data_out = ~nb ^ inv_in;
        end else begin
          valid_out = 1'b1;
          hist_q = {hist_q[21:0], nb};
          bit_data_out = nb ^ inv_in ^ (err_per_in > 0 && cnt >= err_first_in && (cnt - err_first_in) % err_per_in == 0);
        end
        cnt++;
        #400 clk_raw = 1'b1;
        #400 clk_raw = 1'b0;
      end else begin
        cnt = 0;
        bit_data_out = ~bit_data_out;
        #100;
      end
    end
  end
endmodule : prbsc_dut_model

// ---- tb/prbsc_checker_tb.sv ----
// Self-checking bench of the sequence checker
`timescale 1ns/1ps
`include "prbsc_consts.svh"

module prbsc_checker_tb;
  logic        clk, rst_n, psel, penable, pwrite, se;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, bclk, bdat, bval, restart, irq;
  logic        run, cinv, inv, vmode;
  int          deg, tap, efirst, eper, err_count, cmp_count;

  always #50 clk = ~clk;

  prbsc_checker #(.WIN_BITS(64), .WIN_ERR_MIN(16)) dut_u (
    .core_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .bit_clk_in(bclk), .bit_data_in(bdat),
    .data_valid_qualifier_in(bval), .measurement_restart_input_in(restart), .irq_out(irq));

  prbsc_dut_model far_u (.bit_clk_out(bclk), .bit_data_out(bdat), .valid_out(bval), .run_in(run),
    .clk_inv_in(cinv), .inv_in(inv), .vmode_in(vmode), .deg_in(deg), .tap_in(tap),
    .err_first_in(efirst), .err_per_in(eper));

  // -------------------------------------------------------------
  // Bus and compare tasks
  // -------------------------------------------------------------
  task automatic close_out();
    $display("Counts: %0d mismatches, %0d comparisons", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 16);
    if (pready !== 1'b1) begin
      err_count++;
      close_out();
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  task automatic irq_is(input logic v);
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, v});
  endtask : irq_is

  task automatic wait_irq();
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk);
      if (irq === 1'b1) return;
    end
    err_count++;
    close_out();
  endtask : wait_irq

  task automatic go(input logic [31:0] ctrl, tl, el, input int fi, pe, dg, tp, input logic vm, ci, iv, hold);
    apb(1'b1, `PRBSC_OFF_CTRL, ctrl);
    apb(1'b1, `PRBSC_OFF_TOT_LIM, tl);
    apb(1'b1, `PRBSC_OFF_ERR_LIM, el);
    @(posedge clk);
    efirst <= fi; eper <= pe; deg <= dg; tap <= tp; vmode <= vm; cinv <= ci; inv <= iv; restart <= hold;
    apb(1'b1, `PRBSC_OFF_CMD, 32'h1);
    run <= 1'b1;
  endtask : go

  task automatic run_case(input logic [31:0] ctrl, tl, el, input int fi, pe, dg, tp,
                          input logic vm, ci, iv, hold, input logic [31:0] et, ee, es);
    go(ctrl, tl, el, fi, pe, dg, tp, vm, ci, iv, hold);
    if (hold) begin
      repeat (300) @(posedge clk);
      rdc(`PRBSC_OFF_TOT_CNT, 32'h0);
      restart <= 1'b0;
    end
    wait_irq();
    run <= 1'b0;
    rdc(`PRBSC_OFF_TOT_CNT, et);
    rdc(`PRBSC_OFF_ERR_CNT, ee);
    rdc(`PRBSC_OFF_STATUS, es);
    rdc(`PRBSC_OFF_INT_STAT, 32'h1);
    apb(1'b1, `PRBSC_OFF_INT_MASK, 32'h0);
    irq_is(1'b0);
    apb(1'b1, `PRBSC_OFF_INT_MASK, 32'h3);
    irq_is(1'b1);
    apb(1'b1, `PRBSC_OFF_INT_STAT, 32'h3);
    irq_is(1'b0);
  endtask : run_case

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    clk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
    restart = 1'b0; run = 1'b0; cinv = 1'b0; inv = 1'b0; vmode = 1'b0;
    deg = 9; tap = 4; efirst = 0; eper = 0; err_count = 0; cmp_count = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rdc(`PRBSC_OFF_CTRL, 32'h0);
    rdc(`PRBSC_OFF_TOT_LIM, 32'hffff_ffff);
    rdc(`PRBSC_OFF_ERR_LIM, 32'hffff_ffff);
    rdc(`PRBSC_OFF_INT_MASK, 32'h0);
    rdc(`PRBSC_OFF_CMD, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, se}, 32'h1);
    apb(1'b1, `PRBSC_OFF_INT_MASK, 32'h3);
    run_case(32'h0, 32'h28, 32'hffff_ffff, 0, 0, 9, 4, 0, 0, 0, 0, 32'h28, 32'h0, 32'h0c);
    run_case(32'h0, 32'h3e8, 32'h3, 19, 10, 9, 4, 0, 0, 0, 0, 32'h1f, 32'h3, 32'h14);
    run_case(32'h0c, 32'h1e, 32'hffff_ffff, 0, 0, 9, 4, 1, 0, 0, 0, 32'h1e, 32'h0, 32'h0c);
    run_case(32'h103, 32'h19, 32'hffff_ffff, 0, 0, 11, 2, 0, 1, 1, 0, 32'h19, 32'h0, 32'h0c);
    // Inverted-output polynomials: the far side sends the complement
    run_case(32'h200, 32'h19, 32'hffff_ffff, 0, 0, 15, 1, 0, 0, 1, 0, 32'h19, 32'h0, 32'h0c);
    run_case(32'h600, 32'h19, 32'hffff_ffff, 0, 0, 23, 5, 0, 0, 1, 0, 32'h19, 32'h0, 32'h0c);
    run_case(32'h0, 32'h5, 32'h5, 9, 1, 9, 4, 0, 0, 0, 0, 32'h5, 32'h5, 32'h1c);
    run_case(32'h10, 32'h14, 32'hffff_ffff, 0, 0, 9, 4, 0, 0, 0, 1, 32'h14, 32'h0, 32'h0c);
    // Corrupted seed: bit 3 lands in the fill, so the first window goes bad
    go(32'h0, 32'hffff_ffff, 32'hffff_ffff, 3, 10000, 9, 4, 1'b0, 1'b0, 1'b0, 1'b0);
    wait_irq();
    rdc(`PRBSC_OFF_INT_STAT, 32'h2);
    apb(1'b1, `PRBSC_OFF_INT_STAT, 32'h3);
    repeat (1600) @(posedge clk);
    rdc(`PRBSC_OFF_ERR_CNT, 32'h0);
    rdc(`PRBSC_OFF_STATUS, 32'h1);
    apb(1'b1, `PRBSC_OFF_CMD, 32'h2);
    rdc(`PRBSC_OFF_STATUS, 32'h0);
    run <= 1'b0;
    close_out();
  end
endmodule : prbsc_checker_tb
